//--- src/lcdc_pkg.sv
// shared constants for the lcd control decode block
package lcdc_pkg;
    localparam int LCDC_PORT_PINS = 8;
    localparam int LCDC_SCAN_LINES = 6;
    localparam int LCDC_DATA_BITS = 32;
    localparam logic [1:0] LCDC_P9_LOW = 2'h0;
    localparam logic [1:0] LCDC_P9_HIGH = 2'h1;
    localparam logic [1:0] LCDC_P9_CLK = 2'h2;
    localparam logic [1:0] LCDC_P9_SEG = 2'h3;
    localparam logic [2:0] LCDC_FD_768 = 3'h3;
    localparam logic [2:0] LCDC_FD_576 = 3'h7;
    localparam logic [2:0] LCDC_FD_384 = 3'h0;
    localparam logic [2:0] LCDC_FD_288 = 3'h4;
    localparam logic [2:0] LCDC_FD_192 = 3'h2;
    localparam logic [9:0] LCDC_DIV_768 = 10'h300;
    localparam logic [9:0] LCDC_DIV_576 = 10'h240;
    localparam logic [9:0] LCDC_DIV_384 = 10'h180;
    localparam logic [9:0] LCDC_DIV_288 = 10'h120;
    localparam logic [9:0] LCDC_DIV_192 = 10'h0C0;
    localparam logic [2:0] LCDC_CT_MAX = 3'h6;
    localparam logic [2:0] LCDC_FD_RST = 3'h0;
    localparam logic [2:0] LCDC_CT_RST = 3'h0;
    localparam logic [3:0] LCDC_PC_RST = 4'h0;
    localparam logic [3:0] LCDC_PC_MAX = 4'h8;
    typedef enum logic [1:0] {LCDC_RUN, LCDC_SLEEP, LCDC_HELD} lcdc_mode_t;
endpackage : lcdc_pkg

//--- src/lcdc_frame_div.sv
// frame-rate divider and half-rate clock generator
`timescale 1ns/10ps
module lcdc_frame_div
    import lcdc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       run,
    input  wire logic [9:0] div_ratio,
    output logic            half_clk,
    output logic            frame_tick
);
    logic [9:0] cnt_r;
    logic [9:0] cnt_nxt;
    logic       half_r;
    logic       half_nxt;
    logic       tick_r;
    logic       tick_nxt;

    always_comb begin
        cnt_nxt  = cnt_r;
        half_nxt = half_r;
        tick_nxt = 1'b0;
        if (!run) begin
            cnt_nxt  = 10'h000;
            half_nxt = 1'b0;
        end else begin
            half_nxt = ~half_r;
            if (cnt_r >= div_ratio - 10'h001) begin
                cnt_nxt  = 10'h000;
                tick_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 10'h001;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r  <= 10'h000;
            half_r <= 1'b0;
            tick_r <= 1'b0;
        end else if (ce) begin
            cnt_r  <= cnt_nxt;
            half_r <= half_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign half_clk   = half_r;
    assign frame_tick = tick_r;

    tick_gap_a: assert property (@(posedge clk) disable iff (rst)
        (ce && run && tick_r && div_ratio == LCDC_DIV_192) ##1 ce [*3]
        |-> !tick_r)
        else $error("frame tick came too early");
endmodule : lcdc_frame_div

//--- src/lcdc_top.sv
// control field decode for an lcd segment driver with key scan
`timescale 1ns/10ps
// Contract
// - Source select 0 runs the RC oscillator, 1 takes an external clock.
// - Shared pin select codes give low, high, clock over two, or segment.
// - The shared pin never shows the divided clock while asleep.
// - Any sleep bit set stops the clocks and drives the segment outputs low.
// - Standby scan levels by code are all, sixth, fifth and sixth, all.
// - Allocation keeps both scan pins, or makes one or both segments.
// - Port count n turns the first n of eight low segment pins into ports.
// - A port pin follows display bit 4k-3 or 3k-2 by drive phase.
// - Segment blank drives off waveforms instead of stopping segments.
// - With scan enabled a press on a high scan line starts a scan.
// - Scan disable stops scans, clears keys and request, sets data out.
// - Frame bits pick division by 768, 576, 384, 288 or 192.
// - Contrast code 0 to 6 lowers the top drive level in seven steps.
// - Reset pin low stops scan and clocks, clears keys, display off.
// - Control transfers are still taken while the reset pin is low.
module lcdc_top
    import lcdc_pkg::*;
#(
    parameter int PINS  = LCDC_PORT_PINS,
    parameter int LINES = LCDC_SCAN_LINES
) (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      ce,
    input  wire logic                      reset_pin_n,
    input  wire logic                      xfer_done,
    input  wire logic                      osc_source_select,
    input  wire logic                      shared_pin_sel_a,
    input  wire logic                      shared_pin_sel_b,
    input  wire logic                      sleep_ctrl_a,
    input  wire logic                      sleep_ctrl_b,
    input  wire logic                      scan_pin_alloc_a,
    input  wire logic                      scan_pin_alloc_b,
    input  wire logic [3:0]                port_count,
    input  wire logic                      segment_blank,
    input  wire logic                      key_scan_disable,
    input  wire logic [2:0]                frame_div,
    input  wire logic [2:0]                contrast,
    input  wire logic                      three_phase,
    input  wire logic [LCDC_DATA_BITS-1:0] disp_data,
    input  wire logic [LINES-1:0]          key_pressed,
    input  wire logic                      read_req_in,
    output logic                           rc_osc_run,
    output logic                           ext_clk_accept,
    output logic                           shared_port_nine,
    output logic                           p9_is_segment,
    output logic [LINES-1:0]               scan_level,
    output logic                           scan_line_one_is_seg,
    output logic                           scan_line_two_is_seg,
    output logic [PINS-1:0]                port_mode,
    output logic [PINS-1:0]                port_level,
    output logic                           seg_drive_low,
    output logic                           seg_off_wave,
    output logic                           scan_start,
    output logic                           key_data_clear,
    output logic                           read_req,
    output logic                           data_out,
    output logic                           frame_tick,
    output logic [2:0]                     contrast_step
);
    logic             osc_r, osc_nxt;
    logic [1:0]       p9_r, p9_nxt;
    logic [1:0]       slp_r, slp_nxt;
    logic [1:0]       kal_r, kal_nxt;
    logic [3:0]       pc_r, pc_nxt;
    logic             blank_r, blank_nxt;
    logic             ksd_r, ksd_nxt;
    logic [2:0]       fd_r, fd_nxt;
    logic [2:0]       ct_r, ct_nxt;
    logic             half_clk;
    logic [9:0]       div_ratio;
    lcdc_mode_t       mode;
    logic [LINES-1:0] scan_lv_r, scan_lv_nxt;
    logic [PINS-1:0]  pmode_r, pmode_nxt;
    logic [PINS-1:0]  plev_r, plev_nxt;
    logic             p9_out_r, p9_out_nxt;
    logic             scan_r, scan_nxt;
    logic             req_r, req_nxt;

    always_comb begin
        osc_nxt   = osc_r;
        p9_nxt    = p9_r;
        slp_nxt   = slp_r;
        kal_nxt   = kal_r;
        pc_nxt    = pc_r;
        blank_nxt = blank_r;
        ksd_nxt   = ksd_r;
        fd_nxt    = fd_r;
        ct_nxt    = ct_r;
        if (xfer_done) begin
            osc_nxt   = osc_source_select;
            p9_nxt    = {shared_pin_sel_b, shared_pin_sel_a};
            slp_nxt   = {sleep_ctrl_b, sleep_ctrl_a};
            kal_nxt   = {scan_pin_alloc_a, scan_pin_alloc_b};
            blank_nxt = segment_blank;
            ksd_nxt   = key_scan_disable;
            // counts above eight clamp to all eight pins
            pc_nxt = (port_count > LCDC_PC_MAX) ? LCDC_PC_MAX : port_count;
            if (frame_div == LCDC_FD_768 || frame_div == LCDC_FD_576 ||
                frame_div == LCDC_FD_384 || frame_div == LCDC_FD_288 ||
                frame_div == LCDC_FD_192) begin
                fd_nxt = frame_div;
            end
            if (contrast <= LCDC_CT_MAX) begin
                ct_nxt = contrast;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_r   <= 1'b0;
            p9_r    <= LCDC_P9_LOW;
            slp_r   <= 2'h0;
            kal_r   <= 2'h0;
            pc_r    <= LCDC_PC_RST;
            blank_r <= 1'b0;
            ksd_r   <= 1'b0;
            fd_r    <= LCDC_FD_RST;
            ct_r    <= LCDC_CT_RST;
        end else if (ce) begin
            osc_r   <= osc_nxt;
            p9_r    <= p9_nxt;
            slp_r   <= slp_nxt;
            kal_r   <= kal_nxt;
            pc_r    <= pc_nxt;
            blank_r <= blank_nxt;
            ksd_r   <= ksd_nxt;
            fd_r    <= fd_nxt;
            ct_r    <= ct_nxt;
        end
    end

    // held while reset pin low, else sleep when any sleep bit set
    always_comb begin
        if (!reset_pin_n) begin
            mode = LCDC_HELD;
        end else if (slp_r != 2'h0) begin
            mode = LCDC_SLEEP;
        end else begin
            mode = LCDC_RUN;
        end
    end

    always_comb begin
        case (fd_r)
            LCDC_FD_768: div_ratio = LCDC_DIV_768;
            LCDC_FD_576: div_ratio = LCDC_DIV_576;
            LCDC_FD_288: div_ratio = LCDC_DIV_288;
            LCDC_FD_192: div_ratio = LCDC_DIV_192;
            default:     div_ratio = LCDC_DIV_384;
        endcase
    end

    lcdc_frame_div u_div (
        .clk        (clk),
        .rst        (rst),
        .ce         (ce),
        .run        (mode == LCDC_RUN),
        .div_ratio  (div_ratio),
        .half_clk   (half_clk),
        .frame_tick (frame_tick)
    );

    always_comb begin
        scan_lv_nxt = '1;
        pmode_nxt   = '0;
        plev_nxt    = '0;
        p9_out_nxt  = 1'b0;
        scan_nxt    = 1'b0;
        req_nxt     = read_req_in;
        case (mode)
            LCDC_HELD: begin
                scan_lv_nxt = '0;
                req_nxt     = 1'b0;
            end
            LCDC_SLEEP: begin
                case (slp_r)
                    2'h2:    scan_lv_nxt = {1'b1, {(LINES-1){1'b0}}};
                    2'h1:    scan_lv_nxt = {2'h3, {(LINES-2){1'b0}}};
                    default: scan_lv_nxt = '1;
                endcase
                p9_out_nxt = (p9_r == LCDC_P9_HIGH);
            end
            default: begin
                case (p9_r)
                    LCDC_P9_HIGH: p9_out_nxt = 1'b1;
                    LCDC_P9_CLK:  p9_out_nxt = half_clk;
                    default:      p9_out_nxt = 1'b0;
                endcase
            end
        endcase
        if (mode != LCDC_HELD) begin
            for (int k = 0; k < PINS; k++) begin
                pmode_nxt[k] = (k < int'(pc_r));
                plev_nxt[k] = pmode_nxt[k] &
                    (three_phase ? disp_data[3*k] : disp_data[4*k]);
            end
            // scan on press on a high line
            scan_nxt = !ksd_r && |(key_pressed & scan_lv_nxt);
            if (ksd_r) begin
                req_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scan_lv_r <= '0;
            pmode_r   <= '0;
            plev_r    <= '0;
            p9_out_r  <= 1'b0;
            scan_r    <= 1'b0;
            req_r     <= 1'b0;
        end else if (ce) begin
            scan_lv_r <= scan_lv_nxt;
            pmode_r   <= pmode_nxt;
            plev_r    <= plev_nxt;
            p9_out_r  <= p9_out_nxt;
            scan_r    <= scan_nxt;
            req_r     <= req_nxt;
        end
    end

    assign rc_osc_run     = (mode == LCDC_RUN) && !osc_r;
    assign ext_clk_accept = (mode == LCDC_RUN) && osc_r;
    assign shared_port_nine = p9_out_r;
    assign p9_is_segment  = (mode != LCDC_HELD) && (p9_r == LCDC_P9_SEG);
    assign scan_level     = scan_lv_r;
    assign scan_line_one_is_seg = kal_r[1] | kal_r[0];
    assign scan_line_two_is_seg = kal_r[1];
    assign port_mode      = pmode_r;
    assign port_level     = plev_r;
    assign seg_drive_low  = (mode != LCDC_RUN);
    assign seg_off_wave   = (mode == LCDC_RUN) && blank_r;
    assign scan_start     = scan_r;
    assign key_data_clear = ksd_r || (mode == LCDC_HELD);
    assign read_req       = req_r;
    assign data_out       = ksd_r ? 1'b1 : !req_r;
    assign contrast_step  = ct_r;

    p9_sleep_a: assert property (@(posedge clk) disable iff (rst)
        (ce && mode == LCDC_SLEEP && p9_r == LCDC_P9_CLK)
        |=> !shared_port_nine)
        else $error("shared pin clocked while asleep");
    sleep_stop_a: assert property (@(posedge clk) disable iff (rst)
        (slp_r != 2'h0) |-> !rc_osc_run && !ext_clk_accept && seg_drive_low)
        else $error("clock ran during sleep");
    standby_lv_a: assert property (@(posedge clk) disable iff (rst)
        (ce && reset_pin_n && slp_r == 2'h2 && !xfer_done)
        |=> scan_level == {1'b1, {(LINES-1){1'b0}}})
        else $error("standby scan levels wrong");
    dis_dout_a: assert property (@(posedge clk) disable iff (rst)
        ksd_r |-> data_out && key_data_clear ##1 (!ce || !scan_start))
        else $error("scan disable not honoured");
    held_low_a: assert property (@(posedge clk) disable iff (rst)
        (ce && !reset_pin_n) |=> scan_level == '0 && port_mode == '0)
        else $error("reset pin hold failed");
    fd_keep_a: assert property (@(posedge clk) disable iff (rst)
        (ce && xfer_done && frame_div == 3'h6) |=> $stable(fd_r))
        else $error("reserved frame code accepted");
    // fields load only on transfer end
    hold_a: assert property (@(posedge clk) disable iff (rst)
        !xfer_done |=> $stable(p9_r) && $stable(pc_r) && $stable(kal_r))
        else $error("field changed without transfer");
    port_cnt_a: assert property (@(posedge clk) disable iff (rst)
        (ce && reset_pin_n && !xfer_done && pc_r == 4'h3) |=>
        port_mode == 8'h07)
        else $error("port count decode wrong");
endmodule : lcdc_top

//--- testbench/lcdc_ctrl_model.sv
// system controller model that loads control fields
`timescale 1ns/10ps
module lcdc_ctrl_model (
    input  wire logic   clk,
    output logic        xfer_done,
    output logic [18:0] fields
);
    initial begin
        xfer_done = 1'b0;
        fields    = 19'h00000;
    end
    // reserved codes passed as commanded
    // fields scrambled once the transfer ends
    task automatic send(input logic [18:0] v);
        @(posedge clk);
        fields    <= v;
        xfer_done <= 1'b1;
        @(posedge clk);
        fields    <= ~v;
        xfer_done <= 1'b0;
    endtask : send
endmodule : lcdc_ctrl_model

//--- testbench/lcdc_top_test.sv
// self-checking bench for the lcd control decode block
`timescale 1ns/10ps
module lcdc_top_test;
    import lcdc_pkg::*;
    logic        clk, rst, ce, reset_pin_n, three_phase, read_req_in;
    logic [31:0] disp_data;
    logic [5:0]  key_pressed, scan_level;
    logic [7:0]  port_mode, port_level, msk, lvl;
    logic [2:0]  contrast_step;
    logic [18:0] f, fld;
    logic        xfer_done, rc_osc_run, ext_clk_accept, shared_port_nine;
    logic        p9_is_segment, seg_one, seg_two, seg_drive_low;
    logic        seg_off_wave, scan_start, key_data_clear, read_req;
    logic        data_out, frame_tick, a_v, b_v;
    int          fail_count, n_checks, cycles, i, k, g;
    logic [2:0]  fcode [8] = '{3'h3, 3'h7, 3'h0, 3'h4,
                               3'h2, 3'h6, 3'h1, 3'h5};
    int          fdiv [8] = '{768, 576, 384, 288, 192, 192, 192, 192};
    logic [5:0]  slp [4] = '{6'h3F, 6'h20, 6'h30, 6'h3F};

    lcdc_ctrl_model ctrl (.clk(clk), .xfer_done(xfer_done), .fields(fld));
    // field order: osc, sel a/b, sleep a/b, alloc a/b, count,
    // blank, scan off, frame, contrast
    lcdc_top DUT (
        .clk(clk), .rst(rst), .ce(ce), .reset_pin_n(reset_pin_n),
        .xfer_done(xfer_done), .osc_source_select(fld[18]),
        .shared_pin_sel_a(fld[17]), .shared_pin_sel_b(fld[16]),
        .sleep_ctrl_a(fld[15]), .sleep_ctrl_b(fld[14]),
        .scan_pin_alloc_a(fld[13]), .scan_pin_alloc_b(fld[12]),
        .port_count(fld[11:8]), .segment_blank(fld[7]),
        .key_scan_disable(fld[6]), .frame_div(fld[5:3]),
        .contrast(fld[2:0]), .three_phase(three_phase),
        .disp_data(disp_data), .key_pressed(key_pressed),
        .read_req_in(read_req_in), .rc_osc_run(rc_osc_run),
        .ext_clk_accept(ext_clk_accept),
        .shared_port_nine(shared_port_nine),
        .p9_is_segment(p9_is_segment), .scan_level(scan_level),
        .scan_line_one_is_seg(seg_one), .scan_line_two_is_seg(seg_two),
        .port_mode(port_mode), .port_level(port_level),
        .seg_drive_low(seg_drive_low), .seg_off_wave(seg_off_wave),
        .scan_start(scan_start), .key_data_clear(key_data_clear),
        .read_req(read_req), .data_out(data_out),
        .frame_tick(frame_tick), .contrast_step(contrast_step)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task automatic wr();
        ctrl.send(f);
        repeat (2) @(posedge clk);
        #1;
    endtask : wr

    task automatic press(input logic [5:0] kv, input logic rq);
        @(posedge clk);
        key_pressed <= kv;
        read_req_in <= rq;
        repeat (2) @(posedge clk);
        #1;
    endtask : press

    task automatic tick(output int gv);
        gv = 0;
        do begin
            @(posedge clk);
            #1;
            gv++;
        end while (frame_tick !== 1'b1 && gv < 1000);
    endtask : tick

    task automatic stop_test();
        if (fail_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fail_count++;
            stop_test();
        end
    end

    initial begin
        rst         = 1'b1;
        ce          = 1'b1;
        reset_pin_n = 1'b1;
        three_phase = 1'b0;
        read_req_in = 1'b0;
        disp_data   = 32'h9A5C36E1;
        key_pressed = 6'h00;
        f           = 19'h00000;
        fail_count  = 0;
        n_checks    = 0;
        cycles      = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 2; i++) begin
            f[18] = i[0];
            wr();
            chk(rc_osc_run, i == 0);
            chk(ext_clk_accept, i == 1);
        end
        for (i = 0; i < 4; i++) begin
            {f[16], f[17]} = i[1:0];
            wr();
            a_v = shared_port_nine;
            @(posedge clk);
            #1;
            b_v = shared_port_nine;
            chk(p9_is_segment, i == 3);
            if (i < 2) chk(a_v, i);
            if (i == 2) chk(a_v ^ b_v, 1);
        end
        // sleep codes, shared pin on clock code
        {f[16], f[17]} = 2'h2;
        for (i = 0; i < 4; i++) begin
            {f[15], f[14]} = i[1:0];
            wr();
            chk(scan_level, slp[i]);
            chk(seg_drive_low, i != 0);
            chk(rc_osc_run | ext_clk_accept, i == 0);
            for (k = 0; k < 3 && i != 0; k++) begin
                chk(shared_port_nine, 0);
                @(posedge clk);
                #1;
            end
        end
        {f[15], f[14]} = 2'h1;
        wr();
        press(6'h01, 1'b0);
        chk(scan_start, 0);
        press(6'h20, 1'b0);
        chk(scan_start, 1);
        {f[15], f[14]} = 2'h0;
        press(6'h3F, 1'b1);
        chk(read_req, 1);
        chk(data_out, 0);
        f[6] = 1'b1;
        wr();
        chk(scan_start, 0);
        chk(key_data_clear, 1);
        chk(read_req, 0);
        chk(data_out, 1);
        f[6] = 1'b0;
        press(6'h00, 1'b0);
        for (i = 0; i < 4; i++) begin
            f[13:12] = i[1:0];
            wr();
            chk(seg_one, i != 0);
            chk(seg_two, i >= 2);
        end
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            three_phase <= (i >= 10);
            f[11:8] = 4'(i % 10);
            wr();
            msk = 8'((1 << ((i % 10) > 8 ? 8 : (i % 10))) - 1);
            for (k = 0; k < 8; k++)
                lvl[k] = disp_data[(i >= 10) ? 3 * k : 4 * k];
            chk(port_mode, msk);
            chk(port_level & msk, lvl & msk);
        end
        for (i = 1; i >= 0; i--) begin
            f[7] = i[0];
            wr();
            chk(seg_off_wave, i);
        end
        // frame divider, reserved codes keep last
        for (i = 0; i < 8; i++) begin
            f[5:3] = fcode[i];
            wr();
            tick(g);
            tick(g);
            tick(g);
            chk(g, fdiv[i]);
        end
        for (i = 0; i < 8; i++) begin
            f[2:0] = 3'(i);
            wr();
            chk(contrast_step, (i == 7) ? 6 : i);
        end
        // transfer ignored while clock enable is low
        @(posedge clk);
        ce <= 1'b0;
        f[2:0] = 3'h2;
        wr();
        chk(contrast_step, 6);
        @(posedge clk);
        ce <= 1'b1;
        // reset pin held, fields still load
        @(posedge clk);
        reset_pin_n <= 1'b0;
        f[11:8] = 4'h5;
        wr();
        chk(port_mode, 0);
        chk(scan_level, 0);
        chk(rc_osc_run | ext_clk_accept, 0);
        chk(seg_drive_low, 1);
        @(posedge clk);
        reset_pin_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(port_mode, 8'h1F);
        stop_test();
    end
endmodule : lcdc_top_test
